// File: asl_defines.svh
// Purpose: Constants for the aux-store / long-immediate subtract datapath.
// Assumes: 16-bit instruction words, 32-bit main sum register.
// Notes:   Offsets are indices of the plain register port.
`ifndef ASL_DEFINES_SVH
`define ASL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define ASL_REG_CTRL      4'h0
`define ASL_REG_SUM       4'h1
`define ASL_REG_FLAGS     4'h2
`define ASL_REG_INT_STAT  4'h3
`define ASL_REG_INT_MASK  4'h4
`define ASL_REG_PC        4'h5
`define ASL_REG_AUX_BASE  4'h8

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ASL_CTRL_SXM_BIT  0
`define ASL_CTRL_OVM_BIT  1
`define ASL_CTRL_ENH_BIT  2
`define ASL_FLAG_OV_BIT   0
`define ASL_FLAG_C_BIT    1
`define ASL_EVT_OV_BIT    0
`define ASL_EVT_SUB_BIT   1
`define ASL_EVT_STORE_BIT 2
`define ASL_CTRL_RESET    3'h0
`define ASL_PC_RESET      16'h0000

// ----------------------------------------------------------------------
// Opcode encodings and saturation limits
// ----------------------------------------------------------------------
`define ASL_OP_STORE_AUX  5'h0E
`define ASL_OP_SUB_HI     4'hD
`define ASL_OP_SUB_LO     8'h03
`define ASL_POS_LIMIT     32'h7FFF_FFFF
`define ASL_NEG_LIMIT     32'h8000_0000

`endif

// File: asl_pkg.sv
// Purpose: Types for the aux-store / long-immediate subtract datapath.
// Assumes: Nothing beyond the defines header.
// Notes:   Constants live in asl_defines.svh.
package asl_pkg;

    typedef struct packed {
        logic [15:0] data;
        logic        valid;
    } asl_word_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic        we;
    } asl_dmem_t;

    typedef enum logic [2:0] {
        ASL_FETCH = 3'b001,
        ASL_CONST = 3'b010,
        ASL_EXEC  = 3'b100
    } asl_state_t;

endpackage

// File: asl_aux_bank.sv
// Purpose: Bank of eight auxiliary index registers with registered read.
// Assumes: One write port, one read port, synchronous reset.
// Notes:   Read data appear the cycle after the address.
`timescale 1ns/1ps
module asl_aux_bank (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Write port
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_sel,
    input  wire logic [15:0] wr_data,
    // Read port
    input  wire logic [2:0]  rd_sel,
    output logic      [15:0] rd_data
);
    logic [15:0] mem_q [8];
    logic [15:0] mem_d [8];
    logic [15:0] rd_d;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (wr_en) begin
            mem_d[wr_sel] = wr_data;
        end
        rd_d = mem_q[rd_sel];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                mem_q[i] <= 16'h0000;
            end
            rd_data <= 16'h0000;
        end else if (ce) begin
            for (int i = 0; i < 8; i++) begin
                mem_q[i] <= mem_d[i];
            end
            rd_data <= rd_d;
        end
    end
endmodule

// File: asl_exec.sv
// Purpose: Executes the aux-index store and the long-immediate subtract.
// Assumes: Program words arrive as valid-qualified words in program order.
// Notes:   Data memory writes are one-cycle strobes.
//          Only direct addressing is decoded; the indirect bit of the
//          store word is ignored, so a store always uses its 7-bit field.
//          Auxiliary registers are write-only through the register port.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "asl_defines.svh"
module asl_exec (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    // Program words
    input  wire asl_pkg::asl_word_t  prog_word,
    output logic                     prog_ready,
    output logic      [15:0]         pc,
    // Data memory
    output asl_pkg::asl_dmem_t       dmem,
    // Register port
    input  wire logic [3:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    // Interrupt
    output logic                     irq
);
    import asl_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] ext_const(input logic [15:0] k,
                                              input logic        sx);
        ext_const = sx ? {{16{k[15]}}, k} : {16'h0000, k};
    endfunction

    function automatic logic hit(input logic [3:0] a,
                                 input logic [3:0] r);
        hit = (a == r);
    endfunction

    function automatic logic is_store_op(input logic [15:0] w);
        is_store_op = (w[15:11] == `ASL_OP_STORE_AUX);
    endfunction

    function automatic logic is_sub_op(input logic [15:0] w);
        is_sub_op = (w[15:12] == `ASL_OP_SUB_HI) &&
                    (w[7:0] == `ASL_OP_SUB_LO);
    endfunction

    // Subtraction overflows only when the operands differ in sign, so the
    // sign of the original sum tells which limit to clamp to.
    function automatic logic [31:0] sat_limit(input logic neg);
        sat_limit = neg ? `ASL_NEG_LIMIT : `ASL_POS_LIMIT;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    asl_state_t  st_q, st_d;
    logic [2:0]  ctrl_q, ctrl_d;
    logic [31:0] sum_q, sum_d;
    logic        ov_q, ov_d, cy_q, cy_d;
    logic [2:0]  stat_q, stat_d, mask_q, mask_d;
    logic [15:0] pc_q, pc_d;
    logic [3:0]  shift_q, shift_d;
    logic [2:0]  aux_sel_q, aux_sel_d;
    logic [15:0] dma_q, dma_d;
    asl_dmem_t   dmem_d;
    logic [31:0] rdata_d;
    logic [2:0]  evt;
    logic        aux_wr;
    logic [15:0] aux_rd;

    logic [31:0] opnd;
    logic [32:0] diff;
    logic        ovf;

    // The bank's read port is addressed from the next-state select, so
    // the registered read data are ready in the execute cycle itself.
    // Reading the bank a cycle later would return a stale register.
    asl_aux_bank u_aux (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .wr_en   (aux_wr),
        .wr_sel  (reg_addr[2:0]),
        .wr_data (reg_wdata[15:0]),
        .rd_sel  (aux_sel_d),
        .rd_data (aux_rd)
    );

    assign aux_wr = ce && reg_wr && reg_addr[3];
    // The store needs one extra cycle for the bank's registered read, so
    // the next program word is held off during that cycle.
    assign prog_ready = (st_q != ASL_EXEC);
    assign pc = pc_q;
    // The interrupt follows registered state only, so it stays high until
    // software clears the status bit or masks it.
    assign irq = |(stat_q & mask_q);

    // ------------------------------------------------------------------
    // Subtract datapath
    // ------------------------------------------------------------------
    // The constant is used straight off the program bus in the cycle it
    // is taken, so it needs no holding register of its own.
    always_comb begin
        opnd = ext_const(prog_word.data, ctrl_q[`ASL_CTRL_SXM_BIT])
               << shift_q;
        diff = {1'b0, sum_q} - {1'b0, opnd};
        ovf  = (sum_q[31] != opnd[31]) && (diff[31] != sum_q[31]);
    end

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    // A subtract takes its opcode word, then its constant word, and
    // commits sum, flags and counter at the edge that takes the constant.
    // A store takes its word, spends one cycle on the bank's registered
    // read, then drives the data memory write from a register.
    always_comb begin
        st_d       = st_q;
        pc_d       = pc_q;
        shift_d    = shift_q;
        aux_sel_d  = aux_sel_q;
        dma_d      = dma_q;
        sum_d      = sum_q;
        ov_d       = ov_q;
        cy_d       = cy_q;
        dmem_d     = '0;
        evt        = 3'h0;
        unique case (st_q)
            ASL_FETCH: begin
                if (prog_word.valid) begin
                    if (is_store_op(prog_word.data)) begin
                        aux_sel_d  = prog_word.data[10:8];
                        dma_d      = {9'h000, prog_word.data[6:0]};
                        st_d       = ASL_EXEC;
                    end else if (is_sub_op(prog_word.data)) begin
                        shift_d = prog_word.data[11:8];
                        st_d    = ASL_CONST;
                    end else begin
                        // Words this block does not execute are skipped
                        // as one-word instructions.
                        pc_d = pc_q + 16'h0001;
                    end
                end
            end
            ASL_CONST: begin
                // A late constant word simply stalls here; nothing commits
                // until it arrives.
                if (prog_word.valid) begin
                    sum_d = diff[31:0];
                    ov_d  = ovf;
                    if (ovf && ctrl_q[`ASL_CTRL_OVM_BIT]) begin
                        sum_d = sat_limit(sum_q[31]);
                    end
                    if (ctrl_q[`ASL_CTRL_ENH_BIT]) begin
                        cy_d = ~diff[32];
                    end
                    pc_d = pc_q + 16'h0002;
                    evt[`ASL_EVT_SUB_BIT] = 1'b1;
                    evt[`ASL_EVT_OV_BIT]  = ovf;
                    st_d = ASL_FETCH;
                end
            end
            ASL_EXEC: begin
                // store and advance by one
                // The bank output already holds the selected register.
                dmem_d.addr = dma_q;
                dmem_d.data = aux_rd;
                dmem_d.we   = 1'b1;
                pc_d        = pc_q + 16'h0001;
                evt[`ASL_EVT_STORE_BIT] = 1'b1;
                st_d        = ASL_FETCH;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    // Status bits are write-one-to-clear. An event in the same cycle as a
    // clear leaves its bit set, so software never loses an event it has
    // not yet seen.
    always_comb begin
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        stat_d  = stat_q;
        rdata_d = 32'h0000_0000;
        if (reg_wr) begin
            if (hit(reg_addr, `ASL_REG_CTRL)) begin
                ctrl_d = reg_wdata[2:0];
            end
            if (hit(reg_addr, `ASL_REG_INT_MASK)) begin
                mask_d = reg_wdata[2:0];
            end
            if (hit(reg_addr, `ASL_REG_INT_STAT)) begin
                stat_d = stat_q & ~reg_wdata[2:0];
            end
        end
        // Events win over a clear in the same cycle.
        stat_d = stat_d | evt;
        // Read data are zero outside the answer cycle, so a bus that ORs
        // several slaves together never sees a stale word from this one.
        if (reg_rd) begin
            unique case (reg_addr)
                `ASL_REG_CTRL:     rdata_d = {29'h0, ctrl_q};
                `ASL_REG_SUM:      rdata_d = sum_q;
                `ASL_REG_FLAGS:    rdata_d = {30'h0, cy_q, ov_q};
                `ASL_REG_INT_STAT: rdata_d = {29'h0, stat_q};
                `ASL_REG_INT_MASK: rdata_d = {29'h0, mask_q};
                `ASL_REG_PC:       rdata_d = {16'h0000, pc_q};
                default:           rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------------
    // The data memory bus is registered so the write strobe is a clean
    // one-cycle pulse with address and data already settled.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q      <= ASL_FETCH;
            pc_q      <= `ASL_PC_RESET;
            shift_q   <= 4'h0;
            aux_sel_q <= 3'h0;
            dma_q     <= 16'h0000;
            dmem      <= '0;
        end else if (ce) begin
            st_q      <= st_d;
            pc_q      <= pc_d;
            shift_q   <= shift_d;
            aux_sel_q <= aux_sel_d;
            dma_q     <= dma_d;
            dmem      <= dmem_d;
        end
    end

    // ------------------------------------------------------------------
    // Main sum and flag registers
    // ------------------------------------------------------------------
    // The carry keeps its value while the enhanced bit is clear, so code
    // written for the plain variant never sees it move.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sum_q <= 32'h0000_0000;
            ov_q  <= 1'b0;
            cy_q  <= 1'b0;
        end else if (ce) begin
            sum_q <= sum_d;
            ov_q  <= ov_d;
            cy_q  <= cy_d;
        end
    end

    // ------------------------------------------------------------------
    // Control, interrupt and read-back registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q    <= `ASL_CTRL_RESET;
            mask_q    <= 3'h0;
            stat_q    <= 3'h0;
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            ctrl_q    <= ctrl_d;
            mask_q    <= mask_d;
            stat_q    <= stat_d;
            reg_rdata <= rdata_d;
        end
    end
endmodule

// File: asl_exec_asserts.sv
// Purpose: Port-level checks on the aux-store / subtract datapath.
// Assumes: One clock, synchronous active-low reset, ce held high.
// Notes:   Bound onto asl_exec below the module.
`timescale 1ns/1ps
module asl_exec_asserts (
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               ce,
    // Program and data side
    input wire asl_pkg::asl_word_t prog_word,
    input wire logic               prog_ready,
    input wire logic [15:0]        pc,
    input wire asl_pkg::asl_dmem_t dmem,
    // Register port
    input wire logic [3:0]         reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_rdata,
    input wire logic               irq
);
    import asl_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic tk;
    assign tk = prog_word.valid && prog_ready;
    sequence store_take;
        tk && prog_word.data[15:11] == 5'h0E;
    endsequence
    sequence store_done;
        !prog_ready ##1 dmem.we;
    endsequence
    sequence sub_take;
        tk && prog_word.data[15:12] == 4'hD && prog_word.data[7:0] == 8'h03
        ##1 tk;
    endsequence
    a_store_steps: assert property (store_take |=> store_done ##0
        dmem.addr == {9'h000, $past(prog_word.data[6:0], 2)})
        else $error("store did not write the addressed word");
    a_sub_pc_two: assert property (sub_take |=> pc == $past(pc) + 16'h0002)
        else $error("subtract did not advance pc by two");
    a_ready_low: assert property (!prog_ready |-> $past(tk)
        && $past(prog_word.data[15:11]) == 5'h0E)
        else $error("word refused outside store execute");
    a_pc_cause: assert property ($changed(pc) |-> $past(tk) || $past(!prog_ready))
        else $error("pc moved without a taken word");
    a_we_pulse: assert property (dmem.we |=> !dmem.we)
        else $error("memory write strobe longer than one cycle");
    a_dmem_idle: assert property (!dmem.we |-> dmem == '0)
        else $error("memory bus not idle between writes");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside the answer cycle");
    a_irq_masked: assert property (reg_wr && reg_addr == 4'h4 &&
        reg_wdata == 32'h0000_0000 |=> !irq)
        else $error("interrupt stayed high with mask clear");
endmodule
bind asl_exec asl_exec_asserts chk (.clk(clk), .rst_n(rst_n), .ce(ce),
    .prog_word(prog_word), .prog_ready(prog_ready), .pc(pc), .dmem(dmem),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// File: asl_mem_model.sv
// Purpose: Program and data memory standing at the core's far side.
// Assumes: The bench loads words into prog and raises n.
// Notes:   Idle program lines toggle so no stale word looks valid.
`timescale 1ns/1ps
module asl_mem_model (
    // Clock
    input  wire logic               clk,
    // Program side
    output asl_pkg::asl_word_t      prog_word,
    input  wire logic               prog_ready,
    // Data side
    input  wire asl_pkg::asl_dmem_t dmem
);
    import asl_pkg::*;
    logic [15:0] prog [0:31];
    logic [15:0] mem  [0:127];
    logic        flip = 1'b0;
    int          n    = 0;
    int          idx  = 0;
    always_comb begin
        prog_word.valid = idx < n;
        prog_word.data  = (idx < n) ? prog[idx] : {16{flip}};
    end
    always @(posedge clk) begin
        flip <= ~flip;
        if (prog_word.valid && prog_ready)
            idx <= idx + 1;
        if (dmem.we)
            mem[dmem.addr[6:0]] <= dmem.data;
    end
endmodule

// File: asl_exec_test.sv
// Purpose: Self-checking bench for the aux-store / subtract datapath.
// Assumes: 40 MHz clock, ce high except while t_freeze holds it low.
// Notes:   Expected sums are worked out here, step by step.
`timescale 1ns/1ps
`include "asl_defines.svh"
module asl_exec_test;
    import asl_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, irq;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, v, s;
    logic [15:0] pc, pe;
    asl_word_t   prog_word;
    logic        prog_ready;
    asl_dmem_t   dmem;
    int          errors = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    asl_exec dut (.clk(clk), .rst_n(rst_n), .ce(ce), .prog_word(prog_word),
        .prog_ready(prog_ready), .pc(pc), .dmem(dmem), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    asl_mem_model mdl (.clk(clk), .prog_word(prog_word),
        .prog_ready(prog_ready), .dmem(dmem));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Loads up to four words in one edge so they go out back to back.
    task automatic run(input logic [15:0] w0, w1, w2, w3, input int c, dp);
        @(posedge clk);
        mdl.prog[mdl.n] <= w0; mdl.prog[mdl.n + 1] <= w1;
        mdl.prog[mdl.n + 2] <= w2; mdl.prog[mdl.n + 3] <= w3;
        mdl.n <= mdl.n + c;
        pe = pe + 16'(dp);
        for (int i = 0; i < 20 && pc !== pe; i++) begin
            @(posedge clk);
            #1;
        end
        check({16'h0, pc}, {16'h0, pe});
        @(posedge clk);
        #1;
    endtask
    task automatic t_sub_modes;
        rd(4'h0); check(v, 32'h0000_0000);
        wr(4'h0, 32'h0000_0000);
        run(16'hD003, 16'hFFFF, 16'h0, 16'h0, 2, 2); s = s - 32'h0000_FFFF;
        check({16'h0, pc}, {16'h0, pe});
        rd(4'h1); check(v, s);
        wr(4'h0, 32'h0000_0005);
        run(16'hDF03, 16'h0001, 16'h0, 16'h0, 2, 2); s = s - 32'h0000_8000;
        rd(4'h1); check(v, s);
        rd(4'h2); check(v, 32'h0000_0002);
        wr(4'h0, 32'h0000_0001);
        run(16'hD003, 16'hFFFF, 16'h0, 16'h0, 2, 2); s = s + 32'h0000_0001;
        rd(4'h1); check(v, s);
        $display("test sub_modes done");
    endtask
    task automatic t_saturate;
        wr(4'h3, 32'h0000_0007);
        wr(4'h4, 32'h0000_0001);
        wr(4'h0, 32'h0000_0003);
        run(16'hDF03, 16'h7FFF, 16'hDF03, 16'h7FFF, 4, 4);
        s = s - 32'h3FFF_8000;
        rd(4'h1); check(v, `ASL_NEG_LIMIT);
        rd(4'h2); check({31'h0, v[0]}, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0001);
        rd(4'h3); check(v, 32'h0000_0003);
        wr(4'h4, 32'h0000_0000);
        #1 check({31'h0, irq}, 32'h0000_0000);
        wr(4'h3, 32'h0000_0003);
        rd(4'h3); check(v, 32'h0000_0000);
        $display("test saturate done");
    endtask
    task automatic t_store;
        wr(4'hD, 32'h0000_BEEF);
        wr(4'h9, 32'h0000_1234);
        run(16'h752A, 16'h712B, 16'h0, 16'h0, 2, 2);
        check({16'h0, pc}, {16'h0, pe});
        check({16'h0, mdl.mem[7'h2A]}, 32'h0000_BEEF);
        check({16'h0, mdl.mem[7'h2B]}, 32'h0000_1234);
        rd(4'h3); check(v, 32'h0000_0004);
        rd(4'hD); check(v, 32'h0000_0000);
        rd(4'h6); check(v, 32'h0000_0000);
        wr(4'h1, 32'h0000_1111);
        rd(4'h1); check(v, `ASL_NEG_LIMIT);
        $display("test store done");
    endtask
    // Writes to the mask and status registers with the clock enable low must leave both alone.
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        wr(4'h4, 32'h0000_0007);
        wr(4'h3, 32'h0000_0007);
        ce <= 1'b1;
        rd(4'h4);
        check(v, 32'h0000_0000);
        rd(4'h3);
        check(v, 32'h0000_0004);
        check({31'h0, irq}, 32'h0000_0000);
        $display("test freeze done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100us;
        errors++;
        close_out();
    end
    initial begin
        s = 32'h0000_0000;
        pe = `ASL_PC_RESET;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_sub_modes();
        t_saturate();
        t_store();
        t_freeze();
        close_out();
    end
endmodule
